/* File: bench/cfis_engine_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// protocol engine and bus side stand-in
// ****************************************
module cfis_engine_model (
	input  wire logic       clk_in,
	output var  logic [4:0] err_out,  // bus-off, tx/rx passive, tx/rx warning
	output var  logic [4:0] ev_out,   // invalid, wake, overflow, store, tx done
	output var  logic       fifo_out, // store lands in the fifo
	output var  logic [3:0] idx_out   // buffer, filter and tx index
);
	initial begin
		err_out = 5'h00;
		ev_out = 5'h00;
		fifo_out = 1'b0;
		idx_out = 4'hA;
	end
	// error state is a level, held until changed
	task automatic set_err(input logic [4:0] s);
		@(posedge clk_in);
		err_out <= s;
	endtask
	// one-cycle event; index is garbled afterwards so stale values show
	task automatic fire(input logic [4:0] e, input logic f, input logic [3:0] i);
		@(posedge clk_in);
		ev_out <= e;
		fifo_out <= f;
		idx_out <= i;
		@(posedge clk_in);
		ev_out <= 5'h00;
		fifo_out <= 1'b0;
		idx_out <= ~i;
	endtask
endmodule
`default_nettype wire

/* File: bench/cfis_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module cfis_top_bench;
	// ****************************************
	// signals and expectation tables
	// ****************************************
	logic        clk_in = 1'b0, resetn_in = 1'b0;
	logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic [7:0]  paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd_q;
	logic        pready_out, pslverr_out, err_q, data_filter_en_out, irq_out, fifo_s;
	logic [4:0]  data_filter_bits_out, err_s, ev_s;
	logic [5:0]  dma_buffers_out, fifo_write_ptr_out;
	logic [3:0]  idx_s;
	int          n_mismatch = 0, compares = 0, cyc = 0;
	logic [5:0]  bufs [7] = '{6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20};
	logic [4:0]  t_err [7] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h18, 5'h01, 5'h06};
	logic [4:0]  t_ev [7] = '{5'h04, 5'h08, 5'h10, 5'h01, 5'h00, 5'h00, 5'h04};
	logic [31:0] t_flg [7] = '{32'h04, 32'h40, 32'h80, 32'h01, 32'h3020, 32'h0320, 32'h0D24};
	logic [31:0] t_code [7] = '{32'h0C43, 32'h0C42, 32'h0C40, 32'h0C05, 32'h0C41, 32'h0C41, 32'h0C41};
	always #10 clk_in = ~clk_in;
	cfis_engine_model i_eng (.clk_in(clk_in), .err_out(err_s), .ev_out(ev_s), .fifo_out(fifo_s),
		.idx_out(idx_s));
	// filter number is the index rotated, so a swap with the buffer index shows up
	cfis_top i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .tx_bus_off_in(err_s[4]), .tx_error_passive_in(err_s[3]),
		.rx_error_passive_in(err_s[2]), .tx_error_warning_in(err_s[1]),
		.rx_error_warning_in(err_s[0]), .invalid_message_in(ev_s[4]), .wakeup_in(ev_s[3]),
		.rx_overflow_in(ev_s[2]), .rx_store_in(ev_s[1]), .rx_to_fifo_in(fifo_s),
		.rx_buf_idx_in(idx_s), .matched_filter_in({idx_s[0], idx_s[3:1]}),
		.tx_done_in(ev_s[0]),
		.tx_buf_idx_in(idx_s[2:0]), .data_filter_en_out(data_filter_en_out),
		.data_filter_bits_out(data_filter_bits_out), .dma_buffers_out(dma_buffers_out),
		.fifo_write_ptr_out(fifo_write_ptr_out), .irq_out(irq_out));
	// ****************************************
	// compare, bus and closing tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// request held until ready is sampled high, no fixed wait assumed
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		if (n >= 20) n_mismatch++;
		rd_q = prdata_out;
		err_q = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		chk(rd_q, exp);
	endtask
	task automatic end_of_test();
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// hang guard, far above the run length
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		logic [31:0] d;
		repeat (16) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		chk({26'h0, dma_buffers_out}, 32'h4);
		rdchk(8'h04, 32'h0040);
		rdchk(8'h10, 32'h0000);
		$display("test reset done");
		wr(8'h00, 32'hFFFF_FFF1);
		rdchk(8'h00, 32'h0011);
		chk({26'h0, data_filter_en_out, data_filter_bits_out}, 32'h31);
		wr(8'h00, 32'h0000_0000);
		rdchk(8'h00, 32'h0000);
		chk({31'h0, data_filter_en_out}, 32'h0);
		$display("test filter count done");
		for (int k = 0; k < 7; k++) begin
			d = {16'h0000, k[2:0], 8'h00, 2'b00, k[2:0]};
			wr(8'h08, d);
			rdchk(8'h08, d);
			rdchk(8'h0C, {16'h0, 5'h00, d[2:0], 5'h00, d[2:0]});
			chk({26'h0, dma_buffers_out}, {26'h0, bufs[k]});
		end
		$display("test buffer sizes done");
		wr(8'h08, 32'h0000_4005);
		i_eng.fire(5'h02, 1'b1, 4'h9);
		i_eng.fire(5'h02, 1'b1, 4'h9);
		rdchk(8'h0C, 32'h0705);
		chk({26'h0, fifo_write_ptr_out}, 32'h7);
		rdchk(8'h10, 32'h000A);
		rdchk(8'h04, 32'h0C44);
		wr(8'h18, 32'h0000_0000);
		wr(8'h18, 32'h0000_0000);
		i_eng.fire(5'h02, 1'b1, 4'h9);
		rdchk(8'h0C, 32'h0507);
		wr(8'h10, 32'hFFFF_FFF7);
		rdchk(8'h10, 32'h0002);
		rdchk(8'h04, 32'h0C09);
		wr(8'h10, 32'h0000_0000);
		rdchk(8'h04, 32'h0C40);
		$display("test fifo done");
		wr(8'h14, 32'h0000_00EF);
		rdchk(8'h14, 32'h00EF);
		for (int k = 0; k < 7; k++) begin
			i_eng.set_err(t_err[k]);
			i_eng.fire(t_ev[k], 1'b0, 4'h5);
			rdchk(8'h10, t_flg[k]);
			rdchk(8'h04, t_code[k]);
			chk({31'h0, irq_out}, 32'h1);
			wr(8'h10, 32'h0000_0000);
		end
		i_eng.set_err(5'h00);
		wr(8'h14, 32'h0000_0000);
		wr(8'h10, 32'h0000_0000);
		i_eng.fire(5'h04, 1'b0, 4'h5);
		rdchk(8'h10, 32'h0004);
		chk({31'h0, irq_out}, 32'h0);
		$display("test events done");
		rdchk(8'h1C, 32'h0000);
		chk({31'h0, err_q}, 32'h1);
		wr(8'h04, 32'hFFFF_FFFF);
		rdchk(8'h04, 32'h0C43);
		$display("test access done");
		// reset in mid-run must bring size, write pointer and code back
		@(posedge clk_in);
		resetn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk({26'h0, dma_buffers_out}, 32'h4);
		chk({26'h0, fifo_write_ptr_out}, 32'h0);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		rdchk(8'h08, 32'h0000);
		rdchk(8'h04, 32'h0040);
		$display("test reset again done");
		end_of_test();
	end
endmodule
`default_nettype wire

/* File: bench/cfis_top_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// port checker of the status block
// ****************************************
module cfis_top_chk (
	input wire logic        clk_in,
	input wire logic        resetn_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [7:0]  paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic        data_filter_en_out,
	input wire logic [4:0]  data_filter_bits_out,
	input wire logic [5:0]  dma_buffers_out,
	input wire logic [5:0]  fifo_write_ptr_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// size code to buffer count, reserved code read as the largest
	logic [5:0]  bufs_t [8] = '{6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20, 6'h20};
	logic [31:0] wd_q;      // data of the last completed write
	wire         wr_ok = psel_in && penable_in && pready_out && pwrite_in;
	// ****************************************
	// capture write data, it changes after the transfer
	// ****************************************
	always @(posedge clk_in) begin
		if (wr_ok) begin
			wd_q <= pwdata_in;
		end
	end
	a_filt_enable: assert property (data_filter_en_out == (data_filter_bits_out != 5'h00))
		else $error("filter enable disagrees with count");
	a_filt_count: assert property (wr_ok && paddr_in == 8'h00 |-> ##[1:2] data_filter_bits_out == wd_q[4:0])
		else $error("filter count not taken from write");
	a_dma_map: assert property (wr_ok && paddr_in == 8'h08 |-> ##[1:2] dma_buffers_out == bufs_t[wd_q[15:13]])
		else $error("buffer count wrong for size code");
	a_dma_range: assert property (dma_buffers_out inside {6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20})
		else $error("buffer count not a legal size");
	a_ptr_start: assert property (wr_ok && paddr_in == 8'h08 |-> ##[1:2] fifo_write_ptr_out == {1'b0, wd_q[4:0]})
		else $error("write pointer not set to fifo start");
	a_ptr_range: assert property (fifo_write_ptr_out[5] == 1'b0)
		else $error("write pointer beyond 31");
	a_err_zero: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0000_0000)
		else $error("unmapped access returned data");
	a_read_pad: assert property (pready_out |-> prdata_out[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_ready_time: assert property (psel_in && !penable_in |-> ##2 pready_out)
		else $error("answer not after one wait state");
endmodule
bind cfis_top cfis_top_chk i_chk (.clk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in,
	.paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .data_filter_en_out,
	.data_filter_bits_out, .dma_buffers_out, .fifo_write_ptr_out);
`default_nettype wire

/* File: verilog/cfis_defs.vh */
`ifndef CFIS_DEFS_VH
`define CFIS_DEFS_VH

// ****************************************
// register byte addresses
// ****************************************
`define CFIS_ADDR_DFCNT   8'h00
`define CFIS_ADDR_INTERRUPT_SOURCE_CODE   8'h04
`define CFIS_ADDR_FCTRL   8'h08
`define CFIS_ADDR_FSTAT   8'h0C
`define CFIS_ADDR_IFLAG   8'h10
`define CFIS_ADDR_IENA    8'h14
`define CFIS_ADDR_FREL    8'h18

// ****************************************
// field layout
// ****************************************
`define CFIS_FLAG_MASK    8'hEF
`define CFIS_F_INVALID    7
`define CFIS_F_WAKE       6
`define CFIS_F_ERR        5
`define CFIS_F_FIFO       3
`define CFIS_F_OVF        2
`define CFIS_F_RX         1
`define CFIS_F_TX         0

// ****************************************
// interrupt source codes
// ****************************************
`define CFIS_IC_NONE      7'h40
`define CFIS_IC_ERR       7'h41
`define CFIS_IC_WAKE      7'h42
`define CFIS_IC_OVF       7'h43
`define CFIS_IC_FIFO      7'h44

// ****************************************
// dma buffer count encodings
// ****************************************
`define CFIS_DMA_4        3'h0
`define CFIS_DMA_6        3'h1
`define CFIS_DMA_8        3'h2
`define CFIS_DMA_12       3'h3
`define CFIS_DMA_16       3'h4
`define CFIS_DMA_24       3'h5
`define CFIS_DMA_32       3'h6

`endif

/* File: verilog/cfis_interrupt_source_code.v */
`timescale 1ns/100ps
`default_nettype none
`include "cfis_defs.vh"

// ****************************************
// interrupt source code encoder
// ****************************************
module cfis_interrupt_source_code (
	input  wire       clk_in,
	input  wire       resetn_in,
	input  wire [7:0] flags_in,   // pending flags
	input  wire [3:0] rx_idx_in,  // last rx buffer
	input  wire [2:0] tx_idx_in,  // last tx buffer
	output reg  [6:0] code_out    // registered code
);

	reg [6:0] code_d; // next code

	// fixed priority, errors first so bus trouble is never hidden
	always @* begin
		if (flags_in[`CFIS_F_ERR]) begin
			code_d = `CFIS_IC_ERR;
		end else if (flags_in[`CFIS_F_WAKE]) begin
			code_d = `CFIS_IC_WAKE;
		end else if (flags_in[`CFIS_F_OVF]) begin
			code_d = `CFIS_IC_OVF;
		end else if (flags_in[`CFIS_F_FIFO]) begin
			code_d = `CFIS_IC_FIFO;
		end else if (flags_in[`CFIS_F_RX]) begin
			code_d = {3'h0, rx_idx_in};
		end else if (flags_in[`CFIS_F_TX]) begin
			code_d = {4'h0, tx_idx_in};
		end else begin
			code_d = `CFIS_IC_NONE;
		end
	end

	// code register, none pending after reset
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			code_out <= `CFIS_IC_NONE;
		end else begin
			code_out <= code_d;
		end
	end

endmodule
`default_nettype wire

/* File: verilog/cfis_top.v */
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cfis_defs.vh"

module cfis_top (
	input  wire        clk_in,
	input  wire        resetn_in,
	// apb slave
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [7:0]  paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output reg         pready_out,
	output reg         pslverr_out,
	// error state from the protocol engine
	input  wire        tx_bus_off_in,
	input  wire        tx_error_passive_in,
	input  wire        rx_error_passive_in,
	input  wire        tx_error_warning_in,
	input  wire        rx_error_warning_in,
	// event pulses from the protocol engine
	input  wire        invalid_message_in,
	input  wire        wakeup_in,
	input  wire        rx_overflow_in,
	input  wire        rx_store_in,
	input  wire        rx_to_fifo_in,
	input  wire [3:0]  rx_buf_idx_in,
	input  wire [3:0]  matched_filter_in,
	input  wire        tx_done_in,
	input  wire [2:0]  tx_buf_idx_in,
	// outputs to the engine and the cpu
	output reg         data_filter_en_out,
	output reg  [4:0]  data_filter_bits_out,
	output reg  [5:0]  dma_buffers_out,
	output reg  [5:0]  fifo_write_ptr_out,
	output reg         irq_out
);

	// ****************************************
	// apb handshake
	// ****************************************
	wire       req;      // access phase seen
	wire       done;     // completing edge
	wire       wr;       // completing write
	wire       mapped;   // address decodes
	reg        rd_hit;   // decode result

	assign req  = psel_in & penable_in;
	assign done = req & pready_out;
	assign wr   = done & pwrite_in;

	// one wait state: ready rises one edge after access starts
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			pready_out <= 1'b0;
		end else begin
			pready_out <= req & ~pready_out;
		end
	end

	// ****************************************
	// software registers
	// ****************************************
	reg [4:0] dfcnt_q;     // data filter bit count
	reg [2:0] dma_buffer_count_q;     // dma buffer count code
	reg [4:0] fstart_q;    // fifo start buffer
	reg [7:0] iena_q;      // interrupt enables
	reg [7:0] flags_q;     // interrupt flags
	reg [7:0] flags_d;     // next flags
	reg [5:0] status_q;    // error state bits
	reg [5:0] status_d;    // live error state
	reg [3:0] filt_q;      // matched filter number
	reg [3:0] rxidx_q;     // last rx buffer
	reg [2:0] txidx_q;     // last tx buffer
	reg [5:0] wptr_q;      // fifo write pointer
	reg [5:0] rptr_q;      // fifo next read pointer
	reg [5:0] fcnt_q;      // fifo occupancy
	wire [6:0] interrupt_source_code;      // encoded source

	wire wr_dfcnt = wr & (paddr_in == `CFIS_ADDR_DFCNT);
	wire wr_fctrl = wr & (paddr_in == `CFIS_ADDR_FCTRL);
	wire wr_flag  = wr & (paddr_in == `CFIS_ADDR_IFLAG);
	wire wr_iena  = wr & (paddr_in == `CFIS_ADDR_IENA);
	wire wr_frel  = wr & (paddr_in == `CFIS_ADDR_FREL);

	// control registers written by software
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			dfcnt_q  <= 5'h00;
			dma_buffer_count_q  <= `CFIS_DMA_4;
			fstart_q <= 5'h00;
			iena_q   <= 8'h00;
		end else begin
			// odd values are software's to avoid, stored as given
			if (wr_dfcnt) begin
				dfcnt_q <= pwdata_in[4:0];
			end
			if (wr_fctrl) begin
				dma_buffer_count_q  <= pwdata_in[15:13];
				fstart_q <= pwdata_in[4:0];
			end
			if (wr_iena) begin
				iena_q <= pwdata_in[7:0] & `CFIS_FLAG_MASK;
			end
		end
	end

	// ****************************************
	// data byte filter control
	// ****************************************
	// engine compares nothing when the count is zero
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			data_filter_en_out   <= 1'b0;
			data_filter_bits_out <= 5'h00;
		end else begin
			data_filter_en_out   <= (dfcnt_q != 5'h00);
			data_filter_bits_out <= dfcnt_q;
		end
	end

	// ****************************************
	// fifo area and pointers
	// ****************************************
	// buffers in dma memory; reserved code acts as largest
	function [5:0] dma_count;
		input [2:0] code;
		begin
			case (code)
				`CFIS_DMA_4:  dma_count = 6'h04;
				`CFIS_DMA_6:  dma_count = 6'h06;
				`CFIS_DMA_8:  dma_count = 6'h08;
				`CFIS_DMA_12: dma_count = 6'h0C;
				`CFIS_DMA_16: dma_count = 6'h10;
				`CFIS_DMA_24: dma_count = 6'h18;
				default:      dma_count = 6'h20;
			endcase
		end
	endfunction

	wire [5:0] nbuf  = dma_count(dma_buffer_count_q);
	wire [5:0] last  = nbuf - 6'h01;             // top buffer
	wire [5:0] start = {1'b0, fstart_q};
	// fifo size, one at least so a bad start cannot underflow
	wire [5:0] fsize = (start > last) ? 6'h01 : (nbuf - start);

	// step with wrap from top buffer back to the start
	function [5:0] next_ptr;
		input [5:0] p;
		input [5:0] s;
		input [5:0] l;
		begin
			next_ptr = (p >= l) ? s : (p + 6'h01);
		end
	endfunction

	wire store = rx_store_in & rx_to_fifo_in;  // message into fifo
	wire rel   = wr_frel & (fcnt_q != 6'h00);  // buffer released
	wire afull = store & ~rel & (fcnt_q + 6'h02 == fsize);

	// pointers restart at the start buffer when the area moves
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			wptr_q <= 6'h00;
			rptr_q <= 6'h00;
			fcnt_q <= 6'h00;
		end else if (wr_fctrl) begin
			wptr_q <= {1'b0, pwdata_in[4:0]};
			rptr_q <= {1'b0, pwdata_in[4:0]};
			fcnt_q <= 6'h00;
		end else begin
			if (store) begin
				wptr_q <= next_ptr(wptr_q, start, last);
			end
			if (rel) begin
				rptr_q <= next_ptr(rptr_q, start, last);
			end
			// occupancy saturates; overflow is the engine's report
			if (store & ~rel & (fcnt_q != fsize)) begin
				fcnt_q <= fcnt_q + 6'h01;
			end else if (rel & ~store) begin
				fcnt_q <= fcnt_q - 6'h01;
			end
		end
	end

	// pointer and size outputs for the engine
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			fifo_write_ptr_out <= 6'h00;
			dma_buffers_out    <= 6'h04;
		end else begin
			fifo_write_ptr_out <= wptr_q;
			dma_buffers_out    <= nbuf;
		end
	end

	// ****************************************
	// error state and flags
	// ****************************************
	always @* begin
		status_d[5] = tx_bus_off_in;
		status_d[4] = tx_error_passive_in;
		status_d[3] = rx_error_passive_in;
		status_d[2] = tx_error_warning_in;
		status_d[1] = rx_error_warning_in;
		status_d[0] = tx_error_warning_in | rx_error_warning_in;
	end

	// set terms win over a clear in the same cycle
	always @* begin
		flags_d = flags_q;
		if (wr_flag) begin
			flags_d = flags_q & (pwdata_in[7:0] | ~`CFIS_FLAG_MASK);
		end
		// no mode gating: wake-up sets even while disabled
		flags_d[`CFIS_F_WAKE]    = flags_d[`CFIS_F_WAKE] | wakeup_in;
		flags_d[`CFIS_F_INVALID] = flags_d[`CFIS_F_INVALID] | invalid_message_in;
		flags_d[`CFIS_F_ERR]  = flags_d[`CFIS_F_ERR] | (status_d != status_q);
		flags_d[`CFIS_F_FIFO] = flags_d[`CFIS_F_FIFO] | afull;
		flags_d[`CFIS_F_OVF]  = flags_d[`CFIS_F_OVF] | rx_overflow_in;
		flags_d[`CFIS_F_RX]   = flags_d[`CFIS_F_RX] | rx_store_in;
		flags_d[`CFIS_F_TX]   = flags_d[`CFIS_F_TX] | tx_done_in;
		flags_d = flags_d & `CFIS_FLAG_MASK;
	end

	// flags, status and last event indices
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			flags_q  <= 8'h00;
			status_q <= 6'h00;
			filt_q   <= 4'h0;
			rxidx_q  <= 4'h0;
			txidx_q  <= 3'h0;
		end else begin
			flags_q  <= flags_d;
			status_q <= status_d;
			if (rx_store_in) begin
				filt_q  <= matched_filter_in;
				rxidx_q <= rx_buf_idx_in;
			end
			if (tx_done_in) begin
				txidx_q <= tx_buf_idx_in;
			end
		end
	end

	// interrupt request, flag and enable at same position
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(flags_q & iena_q);
		end
	end

	// ****************************************
	// interrupt code encoder
	// ****************************************
	cfis_interrupt_source_code u_interrupt_source_code (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.flags_in  (flags_q),
		.rx_idx_in (rxidx_q),
		.tx_idx_in (txidx_q),
		.code_out  (interrupt_source_code)
	);

	// ****************************************
	// read mux
	// ****************************************
	reg [31:0] rdata; // selected word

	// upper bits stay zero on every register
	always @* begin
		rd_hit = 1'b1;
		rdata  = 32'h00000000;
		case (paddr_in)
			`CFIS_ADDR_DFCNT: begin
				rdata[4:0] = dfcnt_q;
			end
			`CFIS_ADDR_INTERRUPT_SOURCE_CODE: begin
				rdata[12:8] = {1'b0, filt_q};
				rdata[6:0]  = interrupt_source_code;
			end
			`CFIS_ADDR_FCTRL: begin
				rdata[15:13] = dma_buffer_count_q;
				rdata[4:0]   = fstart_q;
			end
			`CFIS_ADDR_FSTAT: begin
				rdata[13:8] = wptr_q;
				rdata[5:0]  = rptr_q;
			end
			`CFIS_ADDR_IFLAG: begin
				rdata[13:8] = status_q;
				rdata[7:0]  = flags_q;
			end
			`CFIS_ADDR_IENA: begin
				rdata[7:0] = iena_q;
			end
			`CFIS_ADDR_FREL: begin
				rdata = 32'h00000000;
			end
			default: begin
				rd_hit = 1'b0; // unmapped
			end
		endcase
	end

	assign mapped = rd_hit;

	// data and error captured in the wait cycle
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			prdata_out  <= 32'h00000000;
			pslverr_out <= 1'b0;
		end else if (req & ~pready_out) begin
			prdata_out  <= pwrite_in ? 32'h00000000 : rdata;
			pslverr_out <= ~mapped;
		end else begin
			prdata_out  <= 32'h00000000;
			pslverr_out <= 1'b0;
		end
	end

endmodule
`default_nettype wire
